// *** design/crc_gen_pkg.sv ***
// Shared constants and types for the programmable CRC generator
package crc_gen_pkg;

    localparam int WORD_W = 32;
    localparam int FIFO_SLOTS = 16;
    localparam int PTR_W = 4;
    localparam int FIELD_W = 5;
    localparam int COUNT_W = 5;
    localparam int BITS_W = 6;

    // Word count limit per data width setting
    localparam logic [COUNT_W-1:0] DEPTH_WIDE = 5'h04;
    localparam logic [COUNT_W-1:0] DEPTH_MID = 5'h08;
    localparam logic [COUNT_W-1:0] DEPTH_NARROW = 5'h10;
    localparam logic [FIELD_W-1:0] WIDE_MIN_FIELD = 5'h10;
    localparam logic [FIELD_W-1:0] MID_MIN_FIELD = 5'h08;

    // Field positions inside a 32-bit word and a 16-bit half
    localparam int HALF_SEL_BIT = 4;
    localparam int BYTE_SEL_BIT = 3;
    localparam int HALF_W = 16;

    // Engine consumes this many bits per cycle
    localparam logic [BITS_W-1:0] BITS_PER_CYCLE = 6'h02;

    // Reset values
    localparam logic [WORD_W-1:0] RESULT_RST = 32'h0000_0000;
    localparam logic [HALF_W-1:0] DATA_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_RST = 5'h00;
    localparam logic [WORD_W-1:0] ALL_ONES_LOW_CLEAR = 32'hFFFF_FFFE;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_SHIFT = 2'b10
    } engine_state_t;

endpackage : crc_gen_pkg

// *** design/crc_word_fifo.sv ***
// Sixteen-slot word FIFO with a live word count
module crc_word_fifo
    import crc_gen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [crc_gen_pkg::WORD_W-1:0] push_word,
    output logic [crc_gen_pkg::WORD_W-1:0] pop_word,
    output logic [crc_gen_pkg::COUNT_W-1:0] count
);
    import crc_gen_pkg::*;

    logic [WORD_W-1:0] mem [FIFO_SLOTS];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [COUNT_W-1:0] count_q, count_d;

    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (clear) begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d = COUNT_RST;
        end else begin
            if (push) begin
                wr_ptr_d = wr_ptr_q + 4'h1;
            end
            if (pop) begin
                rd_ptr_d = rd_ptr_q + 4'h1;
            end
            case ({push, pop})
                2'b10: count_d = count_q + 5'h01;
                2'b01: count_d = count_q - 5'h01;
                default: count_d = count_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= COUNT_RST;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    // Storage carries no reset; the count guards against stale slots
    always_ff @(posedge ref_clk) begin
        if (push && !clear) begin
            mem[wr_ptr_q] <= push_word;
        end
    end

    assign pop_word = mem[rd_ptr_q];
    assign count = count_q;

endmodule : crc_word_fifo

// *** design/crc_bit_step.sv ***
// One input bit through the programmable CRC shift engine
module crc_bit_step
    import crc_gen_pkg::*;
(
    input wire logic [crc_gen_pkg::WORD_W-1:0] crc_in,
    input wire logic data_bit,
    input wire logic [crc_gen_pkg::WORD_W-1:0] taps,
    input wire logic [crc_gen_pkg::WORD_W-1:0] len_mask,
    input wire logic [crc_gen_pkg::FIELD_W-1:0] top_index,
    output logic [crc_gen_pkg::WORD_W-1:0] crc_out
);
    import crc_gen_pkg::*;

    logic feedback;

    // The top term is implicit: it is the bit shifted out at top_index
    assign feedback = data_bit ^ crc_in[top_index];

    genvar i;
    generate
        for (i = 0; i < WORD_W; i++) begin : g_bit
            if (i == 0) begin : g_lsb
                // Constant term always feeds back
                assign crc_out[i] = feedback & len_mask[i];
            end else begin : g_upper
                assign crc_out[i] = (crc_in[i-1] ^ (feedback & taps[i])) & len_mask[i];
            end
        end
    endgenerate

endmodule : crc_bit_step

// *** design/crc_generator.sv ***
// Programmable CRC generator: data staging, FIFO control, shift engine and status
// Summary of operation
// - Polynomial length taken from five-bit field
// - Set term bit enables XOR feedback there
// - Constant term always fed back, bit zero ignored
// - Length 32 implies the top term
// - Data width 1 to 32 bits, five-bit field
// - FIFO depth 4, 8 or 16 by width
// - Byte writes; bits above width ignored
// - Count increments when width MSb byte written
// - Shift starts only with go set and words waiting; a word already shifting finishes after go clears
// - Word moves to buffer, count decrements
// - Two bits per cycle, 32-bit word 16 cycles
// - Full flag at width-dependent depth
// - Empty flag when count is zero
// - Enable low empties FIFO, count zero
// - Direction bit: MSb first default, LSb first set
// - Result stays a normal, non-reflected CRC
// - Width field holds width minus one
// - Length field holds length minus one
// - Select clear: interrupt on count one to zero
// - Go self-clears on completion; software clear silent
module crc_generator
    import crc_gen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic module_enable_bit,
    input wire logic [crc_gen_pkg::FIELD_W-1:0] poly_length_field,
    input wire logic [crc_gen_pkg::FIELD_W-1:0] word_width_field,
    input wire logic [crc_gen_pkg::HALF_W-1:0] poly_terms_low,
    input wire logic [crc_gen_pkg::HALF_W-1:0] poly_terms_high,
    input wire logic shift_direction_bit,
    input wire logic interrupt_select_bit,
    input wire logic go_set,
    input wire logic go_clear,
    input wire logic data_low_wr,
    input wire logic data_high_wr,
    input wire logic [1:0] data_byte_en,
    input wire logic [crc_gen_pkg::HALF_W-1:0] data_wdata,
    input wire logic result_low_wr,
    input wire logic result_high_wr,
    input wire logic [crc_gen_pkg::HALF_W-1:0] result_wdata,
    output logic go_bit,
    output logic [crc_gen_pkg::COUNT_W-1:0] valid_word_count,
    output logic fifo_full_flag,
    output logic fifo_empty_flag,
    output logic [crc_gen_pkg::HALF_W-1:0] data_input_high,
    output logic [crc_gen_pkg::WORD_W-1:0] result_pair,
    output logic crc_irq
);
    import crc_gen_pkg::*;

    // Configuration decode
    logic [WORD_W-1:0] width_mask;
    logic [WORD_W-1:0] len_mask;
    logic [WORD_W-1:0] taps;
    logic [COUNT_W-1:0] depth_lim;

    // Field holds size minus one, so the top bit index is the field itself
    assign width_mask = ~(ALL_ONES_LOW_CLEAR << word_width_field);
    assign len_mask = ~(ALL_ONES_LOW_CLEAR << poly_length_field);
    assign taps = {poly_terms_high, poly_terms_low[HALF_W-1:1], 1'b1} & len_mask;

    always_comb begin
        if (word_width_field >= WIDE_MIN_FIELD) begin
            depth_lim = DEPTH_WIDE;
        end else if (word_width_field >= MID_MIN_FIELD) begin
            depth_lim = DEPTH_MID;
        end else begin
            depth_lim = DEPTH_NARROW;
        end
    end

    // Input staging pair
    logic [HALF_W-1:0] data_low_q, data_low_d;
    logic [HALF_W-1:0] data_high_q, data_high_d;
    logic word_complete;
    logic push_ok;
    logic pop;
    logic [WORD_W-1:0] push_word;
    logic [WORD_W-1:0] pop_word;
    logic [COUNT_W-1:0] count;

    always_comb begin
        data_low_d = data_low_q;
        data_high_d = data_high_q;
        if (!module_enable_bit) begin
            data_high_d = DATA_RST;
        end else begin
            if (data_low_wr && data_byte_en[0]) begin
                data_low_d[7:0] = data_wdata[7:0];
            end
            if (data_low_wr && data_byte_en[1]) begin
                data_low_d[15:8] = data_wdata[15:8];
            end
            if (data_high_wr && data_byte_en[0]) begin
                data_high_d[7:0] = data_wdata[7:0];
            end
            if (data_high_wr && data_byte_en[1]) begin
                data_high_d[15:8] = data_wdata[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_low_q <= DATA_RST;
            data_high_q <= DATA_RST;
        end else begin
            data_low_q <= data_low_d;
            data_high_q <= data_high_d;
        end
    end

    // A word is taken when the byte holding its MSb is written
    assign word_complete = (word_width_field[HALF_SEL_BIT] ? data_high_wr : data_low_wr)
        && data_byte_en[word_width_field[BYTE_SEL_BIT]];
    // Writes into a full FIFO are dropped rather than overwrite queued words
    assign push_ok = module_enable_bit && word_complete && !fifo_full_flag;
    assign push_word = {data_high_d, data_low_d} & width_mask;

    crc_word_fifo u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(!module_enable_bit),
        .push(push_ok),
        .pop(pop),
        .push_word(push_word),
        .pop_word(pop_word),
        .count(count)
    );

    // Shift engine
    engine_state_t eng_state_q, eng_state_d;
    logic [WORD_W-1:0] buf_q, buf_d;
    logic [BITS_W-1:0] bits_left_q, bits_left_d;
    logic [WORD_W-1:0] crc_q, crc_d;
    logic go_q, go_d;
    logic irq_q, irq_d;
    logic complete_evt;
    logic two_bits;
    logic last_step;
    logic bit_first;
    logic bit_second;
    logic [WORD_W-1:0] crc_one;
    logic [WORD_W-1:0] crc_two;

    assign two_bits = bits_left_q >= BITS_PER_CYCLE;
    assign last_step = (eng_state_q == ENG_SHIFT) && (bits_left_q <= BITS_PER_CYCLE);
    // Next word is pulled during the last shift of the current one, so words run back to back
    assign pop = module_enable_bit && go_q && (count != COUNT_RST)
        && ((eng_state_q == ENG_IDLE) || last_step);
    // Completion needs go still set, so a word left shifting after a software stop ends silently
    assign complete_evt = module_enable_bit && go_q && last_step && !pop;

    // Direction picks which end of the buffer feeds the engine; the CRC update is the same for both
    assign bit_first = shift_direction_bit ? buf_q[0] : buf_q[WORD_W-1];
    assign bit_second = shift_direction_bit ? buf_q[1] : buf_q[WORD_W-2];

    crc_bit_step u_step_a (
        .crc_in(crc_q),
        .data_bit(bit_first),
        .taps(taps),
        .len_mask(len_mask),
        .top_index(poly_length_field),
        .crc_out(crc_one)
    );

    crc_bit_step u_step_b (
        .crc_in(crc_one),
        .data_bit(bit_second),
        .taps(taps),
        .len_mask(len_mask),
        .top_index(poly_length_field),
        .crc_out(crc_two)
    );

    always_comb begin
        eng_state_d = eng_state_q;
        buf_d = buf_q;
        bits_left_d = bits_left_q;
        crc_d = crc_q;
        go_d = go_q;
        irq_d = 1'b0;
        if (!module_enable_bit) begin
            eng_state_d = ENG_IDLE;
            buf_d = RESULT_RST;
            bits_left_d = '0;
            crc_d = RESULT_RST;
            go_d = 1'b0;
        end else begin
            case (eng_state_q)
                ENG_IDLE: begin
                    eng_state_d = ENG_IDLE;
                end
                ENG_SHIFT: begin
                    // Galois update, non-reflected whatever the input order
                    crc_d = two_bits ? crc_two : crc_one;
                    if (shift_direction_bit) begin
                        buf_d = buf_q >> 2;
                    end else begin
                        buf_d = buf_q << 2;
                    end
                    bits_left_d = two_bits ? bits_left_q - BITS_PER_CYCLE : '0;
                    if (last_step && !pop) begin
                        eng_state_d = ENG_IDLE;
                    end
                end
                default: begin
                    eng_state_d = ENG_IDLE;
                end
            endcase
            if (pop) begin
                eng_state_d = ENG_SHIFT;
                bits_left_d = {1'b0, word_width_field} + 6'h01;
                if (shift_direction_bit) begin
                    buf_d = pop_word;
                end else begin
                    buf_d = pop_word << (5'h1F - word_width_field);
                end
            end
            if (result_low_wr) begin
                crc_d[HALF_W-1:0] = result_wdata;
            end
            if (result_high_wr) begin
                crc_d[WORD_W-1:HALF_W] = result_wdata;
            end
            if (go_clear || complete_evt) begin
                go_d = 1'b0;
            end
            if (go_set) begin
                go_d = 1'b1;
            end
            if (!interrupt_select_bit && pop && !push_ok && count == 5'h01) begin
                irq_d = 1'b1;
            end
            if (interrupt_select_bit && complete_evt) begin
                irq_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eng_state_q <= ENG_IDLE;
            buf_q <= RESULT_RST;
            bits_left_q <= '0;
            crc_q <= RESULT_RST;
            go_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            eng_state_q <= eng_state_d;
            buf_q <= buf_d;
            bits_left_q <= bits_left_d;
            crc_q <= crc_d;
            go_q <= go_d;
            irq_q <= irq_d;
        end
    end

    assign go_bit = go_q;
    assign valid_word_count = count;
    assign fifo_full_flag = count >= depth_lim;
    assign fifo_empty_flag = count == COUNT_RST;
    assign data_input_high = data_high_q;
    assign result_pair = crc_q;
    assign crc_irq = irq_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    disabled_count_zero_a: assert property (!module_enable_bit |=> valid_word_count == COUNT_RST)
        else $error("count not cleared while disabled");
    empty_flag_a: assert property (fifo_empty_flag == (valid_word_count == COUNT_RST))
        else $error("empty flag disagrees with count");
    full_no_growth_a: assert property ((module_enable_bit && fifo_full_flag && !pop)
        |=> valid_word_count <= $past(valid_word_count))
        else $error("count grew while full");
    idle_without_go_a: assert property ((eng_state_q == ENG_IDLE && !go_bit) |=> eng_state_q == ENG_IDLE)
        else $error("engine started without go");
    word_sixteen_cycles_a: assert property ((pop && word_width_field == 5'h1F && module_enable_bit)
        |=> bits_left_q == 6'h20 ##15 (bits_left_q == 6'h02 || !module_enable_bit))
        else $error("32-bit word not shifted in 16 cycles");
    count_increment_a: assert property ((push_ok && !pop) |=> valid_word_count == $past(valid_word_count) + 5'h01)
        else $error("count did not advance on complete word");
    pop_decrement_a: assert property ((pop && !push_ok) |=> valid_word_count == $past(valid_word_count) - 5'h01)
        else $error("count did not drop on word transfer");
    empty_irq_a: assert property ((module_enable_bit && !interrupt_select_bit && pop && !push_ok
        && valid_word_count == 5'h01) |=> crc_irq)
        else $error("missing interrupt on count one to zero");
    go_self_clear_a: assert property ((complete_evt && !go_set) |=> !go_bit ##0 (crc_irq == $past(interrupt_select_bit)))
        else $error("go not cleared or interrupt wrong at completion");
    sw_clear_silent_a: assert property ((go_clear && !complete_evt && !pop && interrupt_select_bit) |=> !crc_irq)
        else $error("software go clear raised interrupt");

endmodule : crc_generator

// *** test/crc_generator_bench.sv ***
// Self-checking bench for the programmable CRC generator
module crc_generator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import crc_gen_pkg::*;

    logic ref_clk, reset, module_enable_bit, shift_direction_bit, interrupt_select_bit;
    logic [crc_gen_pkg::FIELD_W-1:0] poly_length_field, word_width_field;
    logic [crc_gen_pkg::HALF_W-1:0] poly_terms_low, poly_terms_high, data_wdata, result_wdata;
    logic go_set, go_clear, data_low_wr, data_high_wr, result_low_wr, result_high_wr;
    logic [1:0] data_byte_en;
    logic go_bit, fifo_full_flag, fifo_empty_flag, crc_irq;
    logic [crc_gen_pkg::COUNT_W-1:0] valid_word_count;
    logic [crc_gen_pkg::HALF_W-1:0] data_input_high;
    logic [crc_gen_pkg::WORD_W-1:0] result_pair;

    int errors, num_checks, irq_cnt, cnt, nw, k, depth;
    logic [31:0] r, w, expv, seed, taps;
    logic [31:0] exp_q[$];
    logic prev_go;
    logic [4:0] fields[6] = '{5'h1F, 5'h10, 5'h0F, 5'h08, 5'h07, 5'h00};

    crc_generator dut (.ref_clk(ref_clk), .reset(reset), .module_enable_bit(module_enable_bit),
        .poly_length_field(poly_length_field), .word_width_field(word_width_field),
        .poly_terms_low(poly_terms_low), .poly_terms_high(poly_terms_high),
        .shift_direction_bit(shift_direction_bit), .interrupt_select_bit(interrupt_select_bit),
        .go_set(go_set), .go_clear(go_clear), .data_low_wr(data_low_wr), .data_high_wr(data_high_wr),
        .data_byte_en(data_byte_en), .data_wdata(data_wdata), .result_low_wr(result_low_wr),
        .result_high_wr(result_high_wr), .result_wdata(result_wdata), .go_bit(go_bit),
        .valid_word_count(valid_word_count), .fifo_full_flag(fifo_full_flag),
        .fifo_empty_flag(fifo_empty_flag), .data_input_high(data_input_high),
        .result_pair(result_pair), .crc_irq(crc_irq));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] lmask(input logic [4:0] pf);
        return (pf == 5'h1F) ? 32'hFFFF_FFFF : ((32'h1 << (pf + 1)) - 32'h1);
    endfunction : lmask

    // Bit-serial reference; the top term is the bit shifted out, so length 32 needs no stored term
    function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d, input logic [4:0] wf,
                                            input logic [4:0] pf, input logic [31:0] t, input logic lsb);
        logic b;
        logic fb;
        for (int i = 0; i <= wf; i++) begin
            b = lsb ? d[i] : d[wf - i];
            fb = c[pf] ^ b;
            c = ((c << 1) ^ (fb ? (t | 32'h1) : 32'h0)) & lmask(pf);
        end
        return c;
    endfunction : crc_ref

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Each task waits a fresh edge first, so back-to-back calls never drive a strobe twice in one step
    task automatic wr_half(input logic hi, input logic [1:0] be, input logic [15:0] d);
        @(posedge ref_clk);
        data_low_wr <= ~hi;
        data_high_wr <= hi;
        data_byte_en <= be;
        data_wdata <= d;
        @(posedge ref_clk);
        data_low_wr <= 1'b0;
        data_high_wr <= 1'b0;
    endtask : wr_half

    task automatic wr_result(input logic [31:0] v);
        @(posedge ref_clk);
        result_low_wr <= 1'b1;
        result_wdata <= v[15:0];
        @(posedge ref_clk);
        result_low_wr <= 1'b0;
        result_high_wr <= 1'b1;
        result_wdata <= v[31:16];
        @(posedge ref_clk);
        result_high_wr <= 1'b0;
    endtask : wr_result

    task automatic pulse_enable_low();
        @(posedge ref_clk);
        module_enable_bit <= 1'b0;
        @(posedge ref_clk);
        module_enable_bit <= 1'b1;
        @(negedge ref_clk);
        check(valid_word_count, 32'h0);
        check(fifo_empty_flag, 32'h1);
        check(result_pair, 32'h0);
        check(data_input_high, 32'h0);
    endtask : pulse_enable_low

    // Result watcher: a finished calculation shows as go falling
    initial begin
        prev_go = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (crc_irq === 1'b1) irq_cnt++;
            if (prev_go === 1'b1 && go_bit === 1'b0 && exp_q.size() > 0) check(result_pair, exp_q.pop_front());
            prev_go = go_bit;
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        close_out();
    end

    initial begin
        {reset, module_enable_bit, shift_direction_bit, interrupt_select_bit} = 4'b1100;
        {poly_length_field, word_width_field, poly_terms_low, poly_terms_high} = '0;
        {go_set, go_clear, data_low_wr, data_high_wr, result_low_wr, result_high_wr} = '0;
        {data_byte_en, data_wdata, result_wdata} = '0;
        errors = 0;
        num_checks = 0;
        irq_cnt = 0;
        r = 32'h66F2;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check({go_bit, fifo_full_flag, fifo_empty_flag, valid_word_count}, 32'h20);
        // Fill each depth class to full, then one refused write, then disable
        for (int f = 0; f < 6; f++) begin
            depth = (fields[f] >= 5'h10) ? 4 : (fields[f] >= 5'h08) ? 8 : 16;
            @(posedge ref_clk);
            word_width_field <= fields[f];
            for (k = 0; k <= depth; k++) begin
                r = lfsr(r);
                if (fields[f][4]) wr_half(1'b0, 2'b11, r[15:0]);
                wr_half(fields[f][4], {fields[f][3], 1'b1}, r[31:16]);
                @(negedge ref_clk);
                check(valid_word_count, (k < depth) ? k + 1 : depth);
                check(fifo_full_flag, (k + 1 >= depth) ? 32'h1 : 32'h0);
                check(fifo_empty_flag, 32'h0);
            end
            pulse_enable_low();
        end
        // Random polynomials, widths and directions against the reference
        for (int op = 0; op < 14; op++) begin
            r = lfsr(r);
            taps = lfsr(r);
            nw = 1 + (r[13:12] % 3);
            @(posedge ref_clk);
            poly_length_field <= r[4:0];
            word_width_field <= r[9:5];
            shift_direction_bit <= r[10];
            interrupt_select_bit <= r[11];
            {poly_terms_high, poly_terms_low} <= taps;
            seed = lfsr(taps) & lmask(r[4:0]);
            wr_result(seed);
            repeat (2) @(negedge ref_clk);
            check(valid_word_count, 32'h0);
            check(result_pair, seed);
            expv = seed;
            for (k = 0; k < nw; k++) begin
                w = lfsr(seed ^ k);
                seed = w;
                if (r[9]) begin
                    wr_half(1'b0, 2'b11, w[15:0]);
                    @(negedge ref_clk);
                    check(valid_word_count, k);
                end
                wr_half(r[9], {r[8], 1'b1}, r[9] ? w[31:16] : w[15:0]);
                @(negedge ref_clk);
                check(valid_word_count, k + 1);
                expv = crc_ref(expv, w, r[9:5], r[4:0], taps, r[10]);
            end
            exp_q.push_back(expv);
            irq_cnt = 0;
            @(posedge ref_clk);
            go_set <= 1'b1;
            @(posedge ref_clk);
            go_set <= 1'b0;
            cnt = 0;
            do begin
                @(negedge ref_clk);
                if (go_bit === 1'b1) cnt++;
            end while (go_bit === 1'b1 && cnt < 400);
            check(go_bit, 32'h0);
            check(cnt == nw * ((r[9:5] + 2) / 2) + 1 || cnt == nw * ((r[9:5] + 2) / 2) + 2, 32'h1);
            repeat (3) @(negedge ref_clk);
            check(irq_cnt, 32'h1);
            check(fifo_empty_flag, 32'h1);
        end
        // Software stop in mid-run raises no completion interrupt
        @(posedge ref_clk);
        word_width_field <= 5'h1F;
        interrupt_select_bit <= 1'b1;
        wr_half(1'b0, 2'b11, 16'hA5C3);
        wr_half(1'b1, 2'b11, 16'h3C5A);
        @(negedge ref_clk);
        check(data_input_high, 32'h3C5A);
        irq_cnt = 0;
        @(posedge ref_clk);
        go_set <= 1'b1;
        @(posedge ref_clk);
        go_set <= 1'b0;
        repeat (4) @(posedge ref_clk);
        go_clear <= 1'b1;
        @(posedge ref_clk);
        go_clear <= 1'b0;
        repeat (40) @(negedge ref_clk);
        check(go_bit, 32'h0);
        check(irq_cnt, 32'h0);
        pulse_enable_low();
        close_out();
    end
endmodule : crc_generator_bench
